// >>> audio_link_if.sv
// ======================================================================
// audio serial link between the device and the controller
// assumes the bench drives gp_ext_o and gp_ext_oe for a second processor
`timescale 1ns/1ns
interface audio_link_if;
  logic wclk_dev_o;
  logic wclk_dev_oe;
  logic wclk_host_o;
  logic wclk_host_oe;
  logic bclk_dev_o;
  logic bclk_dev_oe;
  logic bclk_host_o;
  logic bclk_host_oe;
  logic din;
  logic gp_dev_o;
  logic gp_dev_oe;
  logic gp_ext_o;
  logic gp_ext_oe;
  logic wclk;
  logic bclk;
  logic gp;

  // resolved wire levels, undriven lines pulled low
  assign wclk = wclk_dev_oe ? wclk_dev_o : (wclk_host_oe & wclk_host_o);
  assign bclk = bclk_dev_oe ? bclk_dev_o : (bclk_host_oe & bclk_host_o);
  assign gp   = gp_dev_oe ? gp_dev_o : (gp_ext_oe & gp_ext_o);

  modport dev (
    input  wclk, bclk, din, gp,
    output wclk_dev_o, wclk_dev_oe, bclk_dev_o, bclk_dev_oe, gp_dev_o, gp_dev_oe
  );
  modport host (
    input  wclk, bclk,
    output wclk_host_o, wclk_host_oe, bclk_host_o, bclk_host_oe, din
  );
endinterface

// >>> audio_link_properties.sv
// ======================================================================
// link checker on the resolved wires and the driver enables
// assumes one instance beside the link interface, all in the mclk domain
`timescale 1ns/1ns
module audio_link_properties #(
  parameter int BCLK_HALF = 10
) (
  // clock and reset
  input logic mclk,
  input logic rst,
  // resolved wires
  input logic wclk,
  input logic bclk,
  input logic din,
  input logic gp,
  // driver enables
  input logic wclk_dev_oe,
  input logic wclk_host_oe,
  input logic bclk_dev_oe,
  input logic bclk_host_oe,
  input logic gp_dev_oe,
  input logic gp_ext_oe
);
  logic [9:0] hi_q;
  logic [9:0] per_q;
  logic       bclk_q;
  logic       seen_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ======================================================================
  // word clock high time and bit clock period counters
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi_q   <= 10'h0;
      per_q  <= 10'h0;
      bclk_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      hi_q   <= wclk ? hi_q + 10'h1 : 10'h0;
      per_q  <= (bclk && !bclk_q) ? 10'h1 : per_q + 10'h1;
      bclk_q <= bclk;
      seen_q <= seen_q | (bclk & ~bclk_q & bclk_host_oe);
    end
  end

  // ======================================================================
  // assertions
  a_wclk_one_driver: assert property (!(wclk_dev_oe && wclk_host_oe))
    else $error("word clock driven by both ends");
  a_bclk_one_driver: assert property (!(bclk_dev_oe && bclk_host_oe))
    else $error("bit clock driven by both ends");
  a_gp_one_driver: assert property (!(gp_dev_oe && gp_ext_oe))
    else $error("general purpose pin driven by both parties");
  a_din_launch_edge: assert property ($changed(din) && bclk_host_oe |-> $changed(bclk))
    else $error("data changed away from a bit clock edge");
  a_frame_on_launch: assert property ($rose(wclk) && wclk_host_oe && bclk_host_oe |-> $changed(bclk))
    else $error("frame start not on a bit clock edge");
  a_wclk_pulse_len: assert property ($fell(wclk) && wclk_host_oe |-> hi_q == 10'(2 * BCLK_HALF))
    else $error("word clock pulse not one bit clock long");
  a_bclk_period: assert property (bclk && !bclk_q && seen_q && bclk_host_oe
    |-> per_q == 10'(2 * BCLK_HALF)) else $error("bit clock period wrong");
  a_dev_wclk_align: assert property ($rose(wclk) && wclk_dev_oe && bclk_dev_oe
    |-> bclk && (!$past(bclk) || !$past(bclk, 2))) else $error("device frame start off its bit clock rise");

  // covers for the main scenarios
  c_host_frame: cover property ($rose(wclk) && wclk_host_oe);
  c_dev_frame: cover property ($rose(wclk) && wclk_dev_oe);
  c_gp_drive: cover property (gp_dev_oe && $rose(gp));
  c_gp_input: cover property (gp_ext_oe && gp);
endmodule

// >>> audio_port_defines.svh
// ======================================================================
// constants shared by the device end and the controller end of the link
// assumes inclusion by bare name from each design file
`ifndef AUDIO_PORT_DEFINES_SVH
`define AUDIO_PORT_DEFINES_SVH

// ======================================================================
// timing
`define LINK_PERIOD_NS 160
`define MCLK_PERIOD_NS 8

// ======================================================================
// device configuration codes
`define FMT_DSP       2'b01
`define GPF_SWCLK_OUT 4'b1001
`define GPF_SBCLK_OUT 4'b1000
`define GPF_SEC_IN    4'b0001
`define SRC_GP_PIN    3'b000
`define SDIN_GP_PIN   2'b00
`define PW_FROM_SEC   2'b01
`define SW_FROM_PRI   2'b01
`define PB_FROM_SEC   1'b1
`define SB_FROM_INT   1'b1
`define DIN_FROM_SEC  1'b1

// synchroniser lanes
`define PIN_W 3
`define PIN_B 2
`define PIN_D 1
`define PIN_G 0
`define HPIN_W 1
`define HPIN_B 0

// ======================================================================
// controller registers
`define REG_CTRL  32'h0000_0000
`define REG_LEFT  32'h0000_0004
`define REG_RIGHT 32'h0000_0008
`define REG_STAT  32'h0000_000c
`define CTRL_RST  32'h0040_0000
`define C_EN  0
`define C_MST 1
`define C_INV 2
`define C_WL  5:4
`define C_OFF 15:8
`define C_FRM 24:16
`define S_TAKEN 0
`define S_FCNT  31:16
`define RESP_OK  2'b00
`define RESP_ERR 2'b10

`endif

// >>> audio_port_dev.sv
// ======================================================================
// device end: DSP framed audio receiver with primary/secondary routing
// assumes all link pins are asynchronous to mclk; config is static
`timescale 1ns/1ns
`include "audio_port_defines.svh"
module audio_port_dev
  import audio_port_pkg::*;
#(
  parameter int BCLK_HALF = `LINK_PERIOD_NS / (2 * `MCLK_PERIOD_NS)
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // serial link
  audio_link_if.dev        link,
  // framing configuration
  input  wire logic [1:0]  fmt,
  input  wire logic [1:0]  wlen,
  input  wire logic [7:0]  offset,
  input  wire logic [8:0]  frame_bclks,
  input  wire logic        bclk_inv,
  input  wire logic        wclk_square,
  // primary routing
  input  wire logic        wclk_dir,
  input  wire logic        bclk_dir,
  input  wire logic [1:0]  pwclk_sel,
  input  wire logic        pbclk_sel,
  input  wire logic        din_sel,
  // secondary routing
  input  wire logic [2:0]  swclk_src,
  input  wire logic [2:0]  sbclk_src,
  input  wire logic [1:0]  sdin_src,
  input  wire logic [1:0]  swclk_sel,
  input  wire logic        sbclk_sel,
  input  wire logic [3:0]  gp_func,
  // received audio
  output logic      [31:0] left_word,
  output logic      [31:0] right_word,
  output logic             word_valid
);

  // ======================================================================
  // parameter check
  generate
    if (BCLK_HALF < 1 || BCLK_HALF > 255) begin : g_chk
      $error("BCLK_HALF out of range");
    end
  endgenerate

  dev_state_t q;
  dev_state_t d;

  // ======================================================================
  // next state
  always_comb begin
    logic       sec_w;
    logic       sec_b;
    logic       sec_d;
    logic       pri_w;
    logic       pri_b;
    logic       sw_o;
    logic       sb_o;
    logic       dat;
    logic       samp;
    logic [5:0] wl;
    logic [8:0] nidx;
    logic [9:0] pos;
    logic [9:0] two;
    sec_w = 1'b0;
    sec_b = 1'b0;
    sec_d = 1'b0;
    pri_w = 1'b0;
    pri_b = 1'b0;
    sw_o  = 1'b0;
    sb_o  = 1'b0;
    dat   = 1'b0;
    samp  = 1'b0;
    wl    = wlen_bits(wlen);
    nidx  = 9'h000;
    pos   = 10'h000;
    two   = {3'b000, wl, 1'b0};
    d     = q;
    d.valid = 1'b0;

    // two flip-flop synchronisers for every pin
    d.s1 = {link.wclk, link.bclk, link.din, link.gp};
    d.s2 = q.s1;
    d.s3 = q.s2;

    // internal bit clock divider and sample-rate frame clock
    if (q.div == 8'(BCLK_HALF - 1)) begin
      d.div   = 8'h00;
      d.ibclk = ~q.ibclk;
      if (!q.ibclk) begin
        d.fcnt = (q.fcnt + 9'h001 >= frame_bclks) ? 9'h000 : q.fcnt + 9'h001;
        // pulse or square word clock, moved only on a bit clock rise so that
        // no stray frame start appears before the first bit clock edge
        if (wclk_square) begin
          d.iwclk = d.fcnt < (frame_bclks >> 1);
        end else begin
          d.iwclk = d.fcnt == 9'h000;
        end
      end
    end else begin
      d.div = q.div + 8'h01;
    end

    // secondary inputs taken from the general purpose pin
    sec_w = (swclk_src == `SRC_GP_PIN) & q.s2[`PIN_G];
    sec_b = (sbclk_src == `SRC_GP_PIN) & q.s2[`PIN_G];
    sec_d = (sdin_src == `SDIN_GP_PIN) & q.s2[`PIN_G];

    // primary clocks: driven from a selected source or taken from the pin
    if (wclk_dir) begin
      pri_w = (pwclk_sel == `PW_FROM_SEC) ? sec_w : q.iwclk;
    end else begin
      pri_w = q.s2[`PIN_W];
    end
    if (bclk_dir) begin
      pri_b = (pbclk_sel == `PB_FROM_SEC) ? sec_b : q.ibclk;
    end else begin
      pri_b = q.s2[`PIN_B];
    end

    // secondary clock outputs
    sw_o = (swclk_sel == `SW_FROM_PRI) ? pri_w : q.iwclk;
    sb_o = (sbclk_sel == `SB_FROM_INT) ? q.ibclk : pri_b;

    // exactly one data source reaches the receiver
    dat = (din_sel == `DIN_FROM_SEC) ? sec_d : q.s2[`PIN_D];

    // pin drivers
    d.wo  = pri_w;
    d.woe = wclk_dir;
    d.bo  = pri_b;
    d.boe = bclk_dir;
    case (gp_func)
      `GPF_SWCLK_OUT: begin
        d.go  = sw_o;
        d.goe = 1'b1;
      end
      `GPF_SBCLK_OUT: begin
        d.go  = sb_o;
        d.goe = 1'b1;
      end
      default: begin
        d.go  = 1'b0;
        d.goe = 1'b0;
      end
    endcase

    // sampling edge: bit clock fall, or rise when inverted
    d.pbk = pri_b;
    samp  = bclk_inv ? (pri_b & ~q.pbk) : (~pri_b & q.pbk);

    // DSP framing receiver
    if (fmt != `FMT_DSP) begin
      d.lock = 1'b0;
    end else if (samp) begin
      d.pwk = pri_w;
      if (pri_w & ~q.pwk) begin
        nidx   = 9'h000;
        d.lock = 1'b1;
        d.lsh  = 32'h0000_0000;
        d.rsh  = 32'h0000_0000;
      end else if (q.idx != 9'h1ff) begin
        nidx = q.idx + 9'h001;
      end else begin
        nidx = q.idx;
      end
      d.idx = nidx;
      pos   = 10'(nidx) - 10'(offset);
      if (d.lock && nidx >= 9'(offset) && pos < two) begin
        if (pos < 10'(wl)) begin
          d.lsh = {d.lsh[30:0], dat};
        end else begin
          d.rsh = {d.rsh[30:0], dat};
        end
        if (pos == two - 10'h001) begin
          d.left  = d.lsh;
          d.right = d.rsh;
          d.valid = 1'b1;
        end
      end
    end
  end

  // ======================================================================
  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ======================================================================
  // outputs straight from the state register
  assign link.wclk_dev_o  = q.wo;
  assign link.wclk_dev_oe = q.woe;
  assign link.bclk_dev_o  = q.bo;
  assign link.bclk_dev_oe = q.boe;
  assign link.gp_dev_o    = q.go;
  assign link.gp_dev_oe   = q.goe;
  assign left_word        = q.left;
  assign right_word       = q.right;
  assign word_valid       = q.valid;

endmodule

// >>> audio_port_host.sv
// ======================================================================
// controller end: DSP framed audio transmitter with AXI4-Lite registers
// assumes the device samples data on the opposite bit clock edge
`timescale 1ns/1ns
`include "audio_port_defines.svh"
module audio_port_host
  import audio_port_pkg::*;
#(
  parameter int BCLK_HALF = `LINK_PERIOD_NS / (2 * `MCLK_PERIOD_NS)
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // serial link
  audio_link_if.host       link,
  // AXI4-Lite write
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  generate
    if (BCLK_HALF < 1 || BCLK_HALF > 255) begin : g_chk
      $error("BCLK_HALF out of range");
    end
  endgenerate

  // byte lane merge
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    mrg = o;
  endfunction

  host_state_t q;
  host_state_t d;

  // ======================================================================
  // next state
  always_comb begin
    logic       en;
    logic       mst;
    logic       inv;
    logic       tog;
    logic       go;
    logic       be;
    logic       wr;
    logic [5:0] wl;
    logic [8:0] nidx;
    logic [9:0] pos;
    logic [9:0] two;
    en   = q.ctrl[`C_EN];
    mst  = q.ctrl[`C_MST];
    inv  = q.ctrl[`C_INV];
    wl   = wlen_bits(q.ctrl[`C_WL]);
    two  = {3'b000, wl, 1'b0};
    tog  = q.div == 8'(BCLK_HALF - 1);
    go   = 1'b0;
    nidx = 9'h000;
    pos  = 10'h000;
    d    = q;
    d.s1 = {link.wclk, link.bclk};
    d.s2 = q.s1;
    d.s3 = q.s2;
    wr   = q.s2[`HPIN_W] & ~q.s3[`HPIN_W];
    be   = inv ? (~q.s2[`HPIN_B] & q.s3[`HPIN_B]) : (q.s2[`HPIN_B] & ~q.s3[`HPIN_B]);
    d.wh = {q.wh[0], wr};

    // register writes, taken once address and data are both held
    d.awr = 1'b0;
    d.wr  = 1'b0;
    if (q.awr & awvalid) begin
      d.ah = 1'b1;
      d.aa = awaddr;
    end
    if (q.wr & wvalid) begin
      d.wgot = 1'b1;
      d.wd   = wdata;
      d.ws   = wstrb;
    end
    if (q.ah & q.wgot & ~q.bv) begin
      d.ah   = 1'b0;
      d.wgot = 1'b0;
      d.bv   = 1'b1;
      d.br   = `RESP_OK;
      if (q.aa == `REG_CTRL) begin
        d.ctrl = mrg(q.ctrl, q.wd, q.ws);
      end else if (q.aa == `REG_LEFT) begin
        d.left = mrg(q.left, q.wd, q.ws);
      end else if (q.aa == `REG_RIGHT) begin
        d.right = mrg(q.right, q.wd, q.ws);
        d.taken = 1'b0;
      end else if (q.aa != `REG_STAT) begin
        d.br = `RESP_ERR;
      end
    end
    if (q.bv & bready) begin
      d.bv = 1'b0;
    end
    d.awr = ~d.ah & ~d.bv & ~(q.awr & awvalid);
    d.wr  = ~d.wgot & ~d.bv & ~(q.wr & wvalid);

    // register reads
    if (q.arr & arvalid) begin
      d.rv = 1'b1;
      d.rr = `RESP_OK;
      d.rd = 32'h0000_0000;
      if (araddr == `REG_CTRL) begin
        d.rd = q.ctrl;
      end else if (araddr == `REG_LEFT) begin
        d.rd = q.left;
      end else if (araddr == `REG_RIGHT) begin
        d.rd = q.right;
      end else if (araddr == `REG_STAT) begin
        d.rd[`S_FCNT]  = q.fcnt;
        d.rd[`S_TAKEN] = q.taken;
      end else begin
        d.rr = `RESP_ERR;
      end
    end
    if (q.rv & rready) begin
      d.rv = 1'b0;
    end
    d.arr = ~d.rv & ~(q.arr & arvalid);

    // bit clock generation when this end is clock master
    d.div = (tog || !(en & mst)) ? 8'h00 : q.div + 8'h01;
    d.hb  = (en & mst & tog) ? ~q.hb : q.hb;
    if (mst) begin
      go   = tog && (d.hb != inv);
      nidx = (q.idx + 9'h001 >= q.ctrl[`C_FRM]) ? 9'h000 : q.idx + 9'h001;
    end else begin
      go   = wr | (be & (q.wh == 2'b00));
      nidx = wr ? 9'h000 : ((q.idx == 9'h1ff) ? q.idx : q.idx + 9'h001);
    end

    // frame launch: data changes on the edge opposite the sampling edge
    if (!en) begin
      d.idx  = 9'h1ff;
      d.dout = 1'b0;
      d.wo   = 1'b0;
    end else if (go) begin
      d.idx = nidx;
      d.wo  = nidx == 9'h000;
      if (nidx == 9'h000) begin
        d.cl    = q.left;
        d.cr    = q.right;
        d.taken = 1'b1;
        d.fcnt  = q.fcnt + 16'h0001;
      end
      pos    = 10'(nidx) - 10'(q.ctrl[`C_OFF]);
      d.dout = 1'b0;
      if (nidx >= 9'(q.ctrl[`C_OFF]) && pos < two) begin
        if (pos < 10'(wl)) begin
          d.dout = d.cl[5'(10'(wl) - 10'h001 - pos)];
        end else begin
          d.dout = d.cr[5'(two - 10'h001 - pos)];
        end
      end
    end
    d.woe = en & mst;
    d.boe = en & mst;
  end

  // ======================================================================
  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.ctrl <= `CTRL_RST;
      q.idx  <= 9'h1ff;
    end else begin
      q <= d;
    end
  end

  // ======================================================================
  // outputs straight from the state register
  assign link.wclk_host_o  = q.wo;
  assign link.wclk_host_oe = q.woe;
  assign link.bclk_host_o  = q.hb;
  assign link.bclk_host_oe = q.boe;
  assign link.din          = q.dout;
  assign awready           = q.awr;
  assign wready            = q.wr;
  assign bvalid            = q.bv;
  assign bresp             = q.br;
  assign arready           = q.arr;
  assign rvalid            = q.rv;
  assign rresp             = q.rr;
  assign rdata             = q.rd;

endmodule

// >>> audio_port_pkg.sv
// ======================================================================
// types and word length decode for both ends of the audio link
// assumes audio_port_defines.svh is available
package audio_port_pkg;

  // word length code to bit count
  function automatic logic [5:0] wlen_bits(input logic [1:0] c);
    case (c)
      2'b00:   wlen_bits = 6'd16;
      2'b01:   wlen_bits = 6'd20;
      2'b10:   wlen_bits = 6'd24;
      default: wlen_bits = 6'd32;
    endcase
  endfunction

  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [7:0]  div;
    logic        ibclk;
    logic [8:0]  fcnt;
    logic        iwclk;
    logic        pbk;
    logic        pwk;
    logic [8:0]  idx;
    logic        lock;
    logic [31:0] lsh;
    logic [31:0] rsh;
    logic [31:0] left;
    logic [31:0] right;
    logic        valid;
    logic        wo;
    logic        woe;
    logic        bo;
    logic        boe;
    logic        go;
    logic        goe;
  } dev_state_t;

  typedef struct packed {
    logic [1:0]  s1;
    logic [1:0]  s2;
    logic [1:0]  s3;
    logic [7:0]  div;
    logic        hb;
    logic [8:0]  idx;
    logic [1:0]  wh;
    logic        dout;
    logic        wo;
    logic        woe;
    logic        boe;
    logic [31:0] ctrl;
    logic [31:0] left;
    logic [31:0] right;
    logic [31:0] cl;
    logic [31:0] cr;
    logic        taken;
    logic [15:0] fcnt;
    logic        awr;
    logic        wr;
    logic        bv;
    logic        arr;
    logic        rv;
    logic [1:0]  br;
    logic [1:0]  rr;
    logic [31:0] rd;
    logic [31:0] aa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        ah;
    logic        wgot;
  } host_state_t;

endpackage

// >>> tb.sv
// ======================================================================
// testbench joining the controller end and the device end over one link
// assumes the design files and the link checker are compiled first
`timescale 1ns/1ns
`include "audio_port_defines.svh"
module tb;
  localparam int HALF = 10;
  logic        mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, word_valid;
  logic [31:0] awaddr, wdata, araddr, rdata, left_word, right_word;
  logic [1:0]  bresp, rresp, fmt, wlen, pwclk_sel, swclk_sel, sdin_src;
  logic [7:0]  offset;
  logic [8:0]  frame_bclks;
  logic        bclk_inv, wclk_square, wclk_dir, bclk_dir, pbclk_sel, din_sel, sbclk_sel;
  logic [2:0]  swclk_src, sbclk_src;
  logic [3:0]  gp_func;
  int          bad_count, n_compared;

  // ======================================================================
  // the two ends, the link and its checker
  audio_link_if link_if ();
  audio_port_dev #(.BCLK_HALF(HALF)) audio_port_dev_inst (
    .mclk(mclk), .rst(rst), .link(link_if.dev), .fmt(fmt), .wlen(wlen), .offset(offset),
    .frame_bclks(frame_bclks), .bclk_inv(bclk_inv), .wclk_square(wclk_square), .wclk_dir(wclk_dir),
    .bclk_dir(bclk_dir), .pwclk_sel(pwclk_sel), .pbclk_sel(pbclk_sel), .din_sel(din_sel),
    .swclk_src(swclk_src), .sbclk_src(sbclk_src), .sdin_src(sdin_src), .swclk_sel(swclk_sel),
    .sbclk_sel(sbclk_sel), .gp_func(gp_func), .left_word(left_word), .right_word(right_word),
    .word_valid(word_valid));
  audio_port_host #(.BCLK_HALF(HALF)) audio_port_host_inst (
    .mclk(mclk), .rst(rst), .link(link_if.host), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  audio_link_properties #(.BCLK_HALF(HALF)) audio_link_properties_inst (
    .mclk(mclk), .rst(rst), .wclk(link_if.wclk), .bclk(link_if.bclk), .din(link_if.din), .gp(link_if.gp),
    .wclk_dev_oe(link_if.wclk_dev_oe), .wclk_host_oe(link_if.wclk_host_oe),
    .bclk_dev_oe(link_if.bclk_dev_oe), .bclk_host_oe(link_if.bclk_host_oe),
    .gp_dev_oe(link_if.gp_dev_oe), .gp_ext_oe(link_if.gp_ext_oe));

  // ======================================================================
  // common tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  // one write: address and data offered together, bready held until bvalid
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ap, wp, bp;
    int n;
    ap = 1;
    wp = 1;
    bp = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200 && bp; n++) begin
      @(posedge mclk);
      if (ap && awready) begin
        ap = 0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bp = 0;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (bp) begin
      chk("bvalid", 32'h1, 32'h0);
      end_sim();
    end
    @(posedge mclk);
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ap, rp;
    int n;
    ap = 1;
    rp = 1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200 && rp; n++) begin
      @(posedge mclk);
      if (ap && arready) begin
        ap = 0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rp = 0;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (rp) begin
      chk("rvalid", 32'h1, 32'h0);
      end_sim();
    end
    @(posedge mclk);
  endtask

  task automatic wait_valid();
    int n;
    for (n = 0; n < 4000 && word_valid !== 1'b1; n++) @(posedge mclk);
    if (n == 4000) begin
      chk("word_valid", 32'h1, 32'h0);
      end_sim();
    end
    @(posedge mclk);
  endtask

  // program both ends for one run; dm high makes the device the clock master
  task automatic set_link(input logic [1:0] f, input logic [1:0] wl, input logic [7:0] off,
                          input logic [8:0] fr, input logic dm, input logic [31:0] lw, input logic [31:0] rw);
    logic [1:0] r;
    fmt <= f;
    wlen <= wl;
    offset <= off;
    frame_bclks <= fr;
    wclk_dir <= dm;
    bclk_dir <= dm;
    do_reset();
    axi_write(`REG_LEFT, lw, r);
    axi_write(`REG_RIGHT, rw, r);
    axi_write(`REG_CTRL, {7'h0, fr, off, 2'b00, wl, 1'b0, bclk_inv, !dm, 1'b1}, r);
    chk("ctrl_resp", 32'(`RESP_OK), 32'(r));
  endtask

  // second of two frames, words right-justified to the word length
  task automatic chk_frame(input int wl, input logic [31:0] lw, input logic [31:0] rw);
    logic [31:0] m;
    m = (wl == 32) ? 32'hffff_ffff : (32'h1 << wl) - 32'h1;
    wait_valid();
    wait_valid();
    chk("left_word", lw & m, left_word);
    chk("right_word", rw & m, right_word);
  endtask

  // ======================================================================
  // scenarios
  task automatic t_regs();
    logic [1:0]  r;
    logic [31:0] d;
    do_reset();
    axi_read(`REG_CTRL, d, r);
    chk("ctrl_reset", `CTRL_RST, d);
    axi_read(32'h0000_0010, d, r);
    chk("unmapped_read", 32'(`RESP_ERR), 32'(r));
    axi_write(32'h0000_0010, 32'h1, r);
    chk("unmapped_write", 32'(`RESP_ERR), 32'(r));
    axi_write(`REG_LEFT, 32'h5555_aaaa, r);
    axi_read(`REG_LEFT, d, r);
    chk("left_readback", 32'h5555_aaaa, d);
    $display("test regs done");
  endtask

  task automatic t_frame();
    int cnt;
    for (int c = 0; c < 4; c++) begin
      bclk_inv <= (c == 2);
      set_link(`FMT_DSP, c[1:0], 8'(3 * c), 9'd80, 1'b0, 32'h9abc_def1, 32'h2468_ace3);
      chk_frame(16 + 4 * c + 4 * (c / 3), 32'h9abc_def1, 32'h2468_ace3);
    end
    set_link(2'b00, 2'b00, 8'd0, 9'd80, 1'b0, 32'h1, 32'h1);
    cnt = 0;
    repeat (3500) begin
      @(posedge mclk);
      if (word_valid === 1'b1) cnt++;
    end
    chk("ignored_frames", 32'h0, 32'(cnt));
    $display("test frame done");
  endtask

  task automatic t_devmaster();
    for (int sq = 0; sq < 2; sq++) begin
      wclk_square <= sq[0];
      set_link(`FMT_DSP, 2'b10, 8'd1, 9'd64, 1'b1, 32'h00c3_5a7e, 32'h0081_f00d);
      chk_frame(24, 32'h00c3_5a7e, 32'h0081_f00d);
    end
    $display("test devmaster done");
  endtask

  task automatic t_second();
    logic [1:0]  r;
    logic [31:0] d;
    din_sel <= `DIN_FROM_SEC;
    gp_func <= `GPF_SEC_IN;
    link_if.gp_ext_oe <= 1'b1;
    link_if.gp_ext_o <= 1'b1;
    set_link(`FMT_DSP, 2'b00, 8'd0, 9'd40, 1'b0, 32'h0000_1234, 32'h0);
    chk_frame(16, 32'hffff_ffff, 32'hffff_ffff);
    axi_read(`REG_STAT, d, r);
    chk("stat_taken", 32'h1, {31'h0, d[`S_TAKEN]});
    din_sel <= 1'b0;
    $display("test second done");
  endtask

  task automatic t_route();
    int n;
    wclk_dir <= 1'b1;
    bclk_dir <= 1'b1;
    pwclk_sel <= `PW_FROM_SEC;
    pbclk_sel <= `PB_FROM_SEC;
    do_reset();
    for (int k = 0; k < 3; k++) begin
      link_if.gp_ext_o <= (k != 1);
      swclk_src <= (k == 2) ? 3'b001 : `SRC_GP_PIN;
      sbclk_src <= (k == 2) ? 3'b001 : `SRC_GP_PIN;
      repeat (8) @(posedge mclk);
      chk("primary_wclk", 32'(k == 0), 32'(link_if.wclk));
      chk("primary_bclk", 32'(k == 0), 32'(link_if.bclk));
    end
    link_if.gp_ext_oe <= 1'b0;
    wclk_dir <= 1'b0;
    bclk_dir <= 1'b0;
    gp_func <= `GPF_SBCLK_OUT;
    sbclk_sel <= `SB_FROM_INT;
    do_reset();
    n = 0;
    repeat (200) begin
      @(posedge mclk);
      if (link_if.gp === 1'b1) n++;
    end
    chk("gp_bclk_out", 32'h1, 32'(n >= 90 && n <= 110));
    gp_func <= `GPF_SWCLK_OUT;
    swclk_sel <= 2'b00;
    repeat (4) @(posedge mclk);
    chk("gp_wclk_oe", 32'h1, 32'(link_if.gp_dev_oe));
    $display("test route done");
  endtask

  // ======================================================================
  // clock and main sequence
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, wdata, araddr} = '0;
    {fmt, wlen, pwclk_sel, swclk_sel, sdin_src, offset, frame_bclks} = '0;
    {bclk_inv, wclk_square, wclk_dir, bclk_dir, pbclk_sel, din_sel, sbclk_sel} = '0;
    {swclk_src, sbclk_src, gp_func} = '0;
    link_if.gp_ext_o = 1'b0;
    link_if.gp_ext_oe = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_frame();
    t_devmaster();
    t_second();
    t_route();
    end_sim();
  end
endmodule
